// ===== core/sat_defines.vh
// constants for the scope acquisition timebase: register map, fields,
// reset values and timing figures. assumes inclusion by bare name.
`ifndef SAT_DEFINES_VH
`define SAT_DEFINES_VH
// ************************************************************
// widths and sizes
// ************************************************************
`define SAT_DW          16
`define SAT_AW          4
`define SAT_ADC_W       8
`define SAT_DEPTH       8000
`define SAT_PTR_W       13
`define SAT_DAC_CH      16
`define SAT_DAC_W       12
// ************************************************************
// register offsets (word index)
// ************************************************************
`define SAT_REG_CTRL    4'h0
`define SAT_REG_STAT    4'h1
`define SAT_REG_DIV     4'h2
`define SAT_REG_PRE     4'h3
`define SAT_REG_POST    4'h4
`define SAT_REG_DATA    4'h5
`define SAT_REG_FINE    4'h6
`define SAT_REG_WPOS    4'h7
`define SAT_REG_DAC     4'h8
// ************************************************************
// control fields
// ************************************************************
`define SAT_CTL_START   0
`define SAT_CTL_SRC_LO  1
`define SAT_CTL_SRC_HI  2
`define SAT_CTL_FAST    3
`define SAT_CTL_CAL_LO  4
`define SAT_CTL_CAL_HI  5
`define SAT_CTL_SCAL    6
// ************************************************************
// encodings and reset values
// ************************************************************
`define SAT_SRC_CH1     2'h0
`define SAT_SRC_CH2     2'h1
`define SAT_SRC_BUS     2'h2
`define SAT_SRC_EXT     2'h3
`define SAT_CAL_PROBE   2'h0
`define SAT_CAL_TRIG    2'h1
`define SAT_CAL_SELF    2'h2
`define SAT_CAL_REF     2'h3
`define SAT_RST_DIV     16'h0001
`define SAT_RST_CNT     16'h0000
// ************************************************************
// timing
// ************************************************************
`define SAT_REF_MHZ     100
`define SAT_CLK_MHZ     10
`define SAT_STRETCH     500
`define SAT_PROBE_DIV   16'h1388
`define SAT_FINE_MAX    16'hffff
`endif

// ===== core/sat_sync.v
// two-flop synchroniser for a group of pin inputs.
// assumes the inputs are unrelated to sys_clk_i.
`timescale 1ns/1ps
`default_nettype none
module sat_sync #(
  parameter W = 1
) (
  // clock and reset
  input  wire         sys_clk_i,
  input  wire         rst_i,
  // pins in, synchronised out
  input  wire [W-1:0] d_i,
  output reg  [W-1:0] q_o
);
  reg [W-1:0] meta_r;

  // first stage feeds only the second
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_r <= {W{1'b0}};
      q_o    <= {W{1'b0}};
    end
    else
    begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule // sat_sync
`default_nettype wire

// ===== core/sat_rate_div.v
// programmable divider: one-cycle tick every ratio enabled cycles.
// assumes ratio_i is stable while run_i is high; zero acts as one.
`timescale 1ns/1ps
`default_nettype none
module sat_rate_div #(
  parameter W = 16
) (
  // clock and reset
  input  wire         sys_clk_i,
  input  wire         rst_i,
  // control
  input  wire         run_i,
  input  wire         step_i,
  input  wire [W-1:0] ratio_i,
  // output
  output reg          tick_o
);
  reg  [W-1:0] cnt_r;
  wire         last = (cnt_r + {{(W-1){1'b0}}, 1'b1}) >= ratio_i;

  // count steps, restart from zero whenever stopped
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_r  <= {W{1'b0}};
      tick_o <= 1'b0;
    end
    else if (!run_i)
    begin
      cnt_r  <= {W{1'b0}};
      tick_o <= 1'b0;
    end
    else
    begin
      tick_o <= step_i & last;
      if (step_i)
        cnt_r <= last ? {W{1'b0}} : cnt_r + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule // sat_rate_div
`default_nettype wire

// ===== core/sat_top.v
// acquisition control for a two-channel digitising scope: sample
// capture, ring store, trigger routing, pre/post sequencing, fine
// interval measurement, calibration mux and offset dac loading.
// assumes pins are asynchronous and software uses the plain port.
//
// Operation
// RULE1 - each channel yields one eight-bit code per sample clock
// RULE2 - sample clock latches converter output into holding register
// RULE3 - ring store uses 8000 positions per channel
// RULE4 - store is not addressed; write position is a running count
// RULE5 - store clock runs at half rate, writing on both edges
// RULE6 - stored samples reach the host data bus through a buffer
// RULE7 - four trigger sources: channel one, channel two, bus, external
// RULE8 - comparator trigger-true starts acquisition via the time base
// RULE9 - inter-module trigger bus feeds trigger logic directly
// RULE10 - sample rates come from reference via programmable dividers
// RULE11 - fast rates use oscillator locked by divider and phase detector
// RULE12 - arm is sent only after the pre-trigger count elapses
// RULE13 - armed trigger loads and starts the post-trigger down-counter
// RULE14 - countdown zero halts sample clocks and signals completion
// RULE15 - trigger pulse lasts from trigger to next sample clock
// RULE16 - stretcher lengthens that interval about 500 times
// RULE17 - fine counter runs while stretching and its result is stored
// RULE18 - calibration mux picks probe, trigger, self-cal or reference; the reference choice gives ref_r only while fast is set, low otherwise
// RULE19 - sixteen-channel dac sets offsets, levels and static cal
// RULE20 - trigger indications before arm are ignored
// RULE21 - host programs setup first, reads samples after completion
`include "sat_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module sat_top #(
  parameter DEPTH = `SAT_DEPTH,
  parameter PW    = `SAT_PTR_W
) (
  // clock and reset
  input  wire                  sys_clk_i,
  input  wire                  rst_i,
  // register port
  input  wire [`SAT_AW-1:0]    addr_i,
  input  wire [`SAT_DW-1:0]    wdata_i,
  input  wire                  wr_i,
  input  wire                  rd_i,
  output reg  [`SAT_DW-1:0]    rdata_o,
  // converters and trigger pins
  input  wire [`SAT_ADC_W-1:0] adc1_i,
  input  wire [`SAT_ADC_W-1:0] adc2_i,
  input  wire                  cmp1_true_i,
  input  wire                  cmp2_true_i,
  input  wire                  inter_module_trigger_bus_i,
  input  wire                  ext_trig_i,
  // oscillator loop and stretcher
  input  wire                  osc_i,
  output reg                   osc_up_o,
  output reg                   osc_dn_o,
  output reg                   interp_pulse_o,
  input  wire                  stretch_done_i,
  // acquisition outputs
  output reg                   adc_clk_o,
  output reg                   store_clk_o,
  output reg                   arm_o,
  output reg                   done_o,
  output reg                   calibration_output_mux_o,
  // dac load port
  output reg  [3:0]            dac_sel_o,
  output reg  [`SAT_DAC_W-1:0] dac_val_o,
  output reg                   dac_ld_o
);
  // ************************************************************
  // states
  // ************************************************************
  localparam [4:0] S_IDLE  = 5'h01;
  localparam [4:0] S_PRE   = 5'h02;
  localparam [4:0] S_ARMED = 5'h04;
  localparam [4:0] S_POST  = 5'h08;
  localparam [4:0] S_DONE  = 5'h10;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  wire [`SAT_ADC_W-1:0] a1_s;
  wire [`SAT_ADC_W-1:0] a2_s;
  wire [5:0]            p_s;

  sat_sync #(.W(`SAT_ADC_W)) u_sync_a1 (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .d_i       (adc1_i),
    .q_o       (a1_s)
  );
  sat_sync #(.W(`SAT_ADC_W)) u_sync_a2 (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .d_i       (adc2_i),
    .q_o       (a2_s)
  );
  sat_sync #(.W(6)) u_sync_p (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .d_i       ({stretch_done_i, osc_i, ext_trig_i,
                 inter_module_trigger_bus_i, cmp2_true_i, cmp1_true_i}),
    .q_o       (p_s)
  );

  // ************************************************************
  // registers
  // ************************************************************
  reg [6:0]            ctrl_r;
  reg [`SAT_DW-1:0]    div_r;
  reg [`SAT_DW-1:0]    pre_r;
  reg [`SAT_DW-1:0]    post_r;
  reg [`SAT_DW-1:0]    fine_r;
  reg                  fine_ok_r;
  reg [4:0]            st_r;
  reg [`SAT_DW-1:0]    cnt_r;
  reg [PW-1:0]         wpos_r;
  reg [PW-1:0]         rpos_r;
  reg [`SAT_ADC_W-1:0] hold1_r;
  reg [`SAT_ADC_W-1:0] hold2_r;
  reg                  we_r;
  reg [5:0]            p_d_r;
  reg                  stretch_r;
  reg [`SAT_DW-1:0]    fcnt_r;
  reg                  trig_seen_r;
  reg [2*`SAT_ADC_W-1:0] mem [0:DEPTH-1];

  wire       start  = wr_i && addr_i == `SAT_REG_CTRL && wdata_i[`SAT_CTL_START];
  wire [1:0] src    = ctrl_r[`SAT_CTL_SRC_HI:`SAT_CTL_SRC_LO];
  wire       fast   = ctrl_r[`SAT_CTL_FAST];
  wire [1:0] cmode  = ctrl_r[`SAT_CTL_CAL_HI:`SAT_CTL_CAL_LO];
  wire       run    = st_r[1] | st_r[2] | st_r[3];
  wire [5:0] rise   = p_s & ~p_d_r;

  // ************************************************************
  // sample clock generation
  // ************************************************************
  wire div_tick;
  wire ref_tick;
  wire osc_tick;
  wire prb_tick;

  // slow rates: reference divided by the programmed ratio
  sat_rate_div #(.W(`SAT_DW)) u_div (       // [RULE10]
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .run_i     (run & ~fast),
    .step_i    (1'b1),
    .ratio_i   (div_r),
    .tick_o    (div_tick)
  );
  // loop compare: reference and oscillator divided alike
  sat_rate_div #(.W(`SAT_DW)) u_ref (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .run_i     (fast),
    .step_i    (1'b1),
    .ratio_i   (div_r),
    .tick_o    (ref_tick)
  );
  sat_rate_div #(.W(`SAT_DW)) u_osc (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .run_i     (fast),
    .step_i    (rise[4]),
    .ratio_i   (div_r),
    .tick_o    (osc_tick)
  );
  // fixed square wave for probe compensation
  sat_rate_div #(.W(`SAT_DW)) u_prb (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .run_i     (1'b1),
    .step_i    (1'b1),
    .ratio_i   (`SAT_PROBE_DIV),
    .tick_o    (prb_tick)
  );

  // fast rates sample on each rising tunable_sample_oscillator edge
  wire tick = run & (fast ? rise[4] : div_tick);   // [RULE11] [RULE14]

  // digital phase detector: early edge drives the loop, both clear
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      osc_up_o <= 1'b0;
      osc_dn_o <= 1'b0;
    end
    else if (!fast || (osc_up_o && osc_dn_o))
    begin
      osc_up_o <= 1'b0;
      osc_dn_o <= 1'b0;
    end
    else
    begin
      osc_up_o <= osc_up_o | ref_tick;              // [RULE11]
      osc_dn_o <= osc_dn_o | osc_tick;
    end
  end

  // ************************************************************
  // capture and ring store
  // ************************************************************
  // latch on the sample edge, write a cycle later so data is steady
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hold1_r     <= {`SAT_ADC_W{1'b0}};
      hold2_r     <= {`SAT_ADC_W{1'b0}};
      we_r        <= 1'b0;
      adc_clk_o   <= 1'b0;
      store_clk_o <= 1'b0;
      wpos_r      <= {PW{1'b0}};
    end
    else
    begin
      adc_clk_o <= tick;                            // [RULE1]
      we_r      <= tick;
      if (start)
        wpos_r <= {PW{1'b0}};
      if (tick)
      begin
        hold1_r     <= a1_s;                        // [RULE1] [RULE2]
        hold2_r     <= a2_s;
        store_clk_o <= ~store_clk_o;                // [RULE5]
      end
      // position known only by counting store edges
      if (we_r)
        wpos_r <= (wpos_r == DEPTH - 1) ? {PW{1'b0}}
                : wpos_r + {{(PW-1){1'b0}}, 1'b1};  // [RULE3] [RULE4]
    end
  end

  // storage has no reset; each edge of store_clk_o writes one word
  always @(posedge sys_clk_i)
  begin
    if (we_r)
      mem[wpos_r] <= {hold2_r, hold1_r};            // [RULE5]
  end

  // ************************************************************
  // trigger routing
  // ************************************************************
  reg src_hit;
  always @*
  begin
    case (src)                                      // [RULE7]
      `SAT_SRC_CH1: src_hit = rise[0];              // [RULE8]
      `SAT_SRC_CH2: src_hit = rise[1];
      `SAT_SRC_BUS: src_hit = rise[2];              // [RULE9]
      default:      src_hit = rise[3];
    endcase
  end
  // hits before arm are dropped on the floor
  wire take = st_r[2] & src_hit;                    // [RULE20]

  // ************************************************************
  // time base sequencer
  // ************************************************************
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_r   <= S_IDLE;
      cnt_r  <= `SAT_RST_CNT;
      arm_o  <= 1'b0;
      done_o <= 1'b0;
      p_d_r  <= 6'h00;
    end
    else
    begin
      p_d_r <= p_s;
      case (st_r)
        S_IDLE, S_DONE:
        begin
          if (start)                                // [RULE21]
          begin
            st_r   <= S_PRE;
            cnt_r  <= `SAT_RST_CNT;
            done_o <= 1'b0;
          end
        end
        S_PRE:
        begin
          if (cnt_r >= pre_r)
          begin
            st_r  <= S_ARMED;
            arm_o <= 1'b1;                          // [RULE12]
          end
          else if (tick)
            cnt_r <= cnt_r + 16'h0001;              // [RULE12]
        end
        S_ARMED:
        begin
          if (take)
          begin
            st_r  <= S_POST;
            arm_o <= 1'b0;
            cnt_r <= post_r;                        // [RULE13]
          end
        end
        S_POST:
        begin
          if (tick)
          begin
            if (cnt_r == 16'h0000)
            begin
              st_r   <= S_DONE;                     // [RULE14]
              done_o <= 1'b1;
            end
            else
              cnt_r <= cnt_r - 16'h0001;            // [RULE13]
          end
        end
        default:
        begin
          st_r  <= S_IDLE;
          arm_o <= 1'b0;
        end
      endcase
    end
  end

  // ************************************************************
  // fine interval measurement
  // ************************************************************
  // the counter saturates so a dead stretcher cannot hang the block
  wire fine_end = rise[5] || fcnt_r == `SAT_FINE_MAX;
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      interp_pulse_o <= 1'b0;
      stretch_r      <= 1'b0;
      fcnt_r         <= 16'h0000;
      fine_r         <= 16'h0000;
      fine_ok_r      <= 1'b0;
      trig_seen_r    <= 1'b0;
    end
    else
    begin
      if (take)
        trig_seen_r <= 1'b1;
      else if (start)
        trig_seen_r <= 1'b0;
      if (take)
        interp_pulse_o <= 1'b1;                     // [RULE15]
      else if (tick)
        interp_pulse_o <= 1'b0;                     // [RULE15]
      // stretch runs about 500 times the pulse after it ends
      if (interp_pulse_o && tick)
      begin
        stretch_r <= 1'b1;                          // [RULE16]
        fcnt_r    <= 16'h0000;
      end
      else if (stretch_r)
      begin
        if (fine_end)
        begin
          stretch_r <= 1'b0;
          fine_r    <= fcnt_r;                      // [RULE17]
          fine_ok_r <= 1'b1;
        end
        else
          fcnt_r <= fcnt_r + 16'h0001;              // [RULE17]
      end
      else if (start)
        fine_ok_r <= 1'b0;
    end
  end

  // ************************************************************
  // calibration output and dac loading
  // ************************************************************
  reg prb_r;
  reg ref_r;
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      prb_r                    <= 1'b0;
      ref_r                    <= 1'b0;
      calibration_output_mux_o <= 1'b0;
      dac_sel_o                <= 4'h0;
      dac_val_o                <= {`SAT_DAC_W{1'b0}};
      dac_ld_o                 <= 1'b0;
    end
    else
    begin
      ref_r <= ~ref_r;
      if (prb_tick)
        prb_r <= ~prb_r;
      case (cmode)                                  // [RULE18]
        `SAT_CAL_PROBE: calibration_output_mux_o <= prb_r;
        `SAT_CAL_TRIG:  calibration_output_mux_o <= interp_pulse_o;
        `SAT_CAL_SELF:  calibration_output_mux_o <= ctrl_r[`SAT_CTL_SCAL];
        default:        calibration_output_mux_o <= fast & ref_r;
      endcase
      // channel index picks offset, trigger level or static level
      dac_ld_o <= wr_i && addr_i == `SAT_REG_DAC;   // [RULE19]
      if (wr_i && addr_i == `SAT_REG_DAC)
      begin
        dac_sel_o <= wdata_i[15:12];
        dac_val_o <= wdata_i[`SAT_DAC_W-1:0];
      end
    end
  end

  // ************************************************************
  // register port
  // ************************************************************
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl_r  <= 7'h00;
      div_r   <= `SAT_RST_DIV;
      pre_r   <= `SAT_RST_CNT;
      post_r  <= `SAT_RST_CNT;
      rpos_r  <= {PW{1'b0}};
      rdata_o <= 16'h0000;
    end
    else
    begin
      rdata_o <= 16'h0000;
      // newest sample sits at the write position taken on the final tick when ticks are two or more cycles apart
      if (st_r[3] && tick && cnt_r == 16'h0000)
        rpos_r <= wpos_r;
      if (wr_i)
      begin
        case (addr_i)
          `SAT_REG_CTRL: ctrl_r <= {wdata_i[6:1], 1'b0};
          `SAT_REG_DIV:  div_r  <= wdata_i;
          `SAT_REG_PRE:  pre_r  <= wdata_i;
          `SAT_REG_POST: post_r <= wdata_i;
          default:       ;
        endcase
      end
      if (rd_i)
      begin
        case (addr_i)
          `SAT_REG_CTRL: rdata_o <= {9'h000, ctrl_r};
          `SAT_REG_STAT: rdata_o <= {8'h00, fine_ok_r, trig_seen_r,
                                     done_o, st_r};
          `SAT_REG_DIV:  rdata_o <= div_r;
          `SAT_REG_PRE:  rdata_o <= pre_r;
          `SAT_REG_POST: rdata_o <= post_r;
          `SAT_REG_FINE: rdata_o <= fine_r;
          `SAT_REG_WPOS: rdata_o <= {{(16-PW){1'b0}}, wpos_r};
          `SAT_REG_DATA:
          begin
            rdata_o <= mem[rpos_r];                 // [RULE6]
            rpos_r  <= (rpos_r == DEPTH - 1) ? {PW{1'b0}}
                     : rpos_r + {{(PW-1){1'b0}}, 1'b1};
          end
          default:       rdata_o <= 16'h0000;
        endcase
      end
    end
  end
endmodule // sat_top
`default_nettype wire

// ===== dv/sat_monitor.sv
// checker on the acquisition block ports: register port, dac loads,
// arm/done sequencing. assumes it is bound onto sat_top, one clock.
`include "sat_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module sat_monitor (
  // clock and reset
  input wire logic                  sys_clk_i,
  input wire logic                  rst_i,
  // register port
  input wire logic [`SAT_AW-1:0]    addr_i,
  input wire logic [`SAT_DW-1:0]    wdata_i,
  input wire logic                  wr_i,
  input wire logic                  rd_i,
  input wire logic [`SAT_DW-1:0]    rdata_o,
  // sequencing outputs
  input wire logic                  osc_up_o,
  input wire logic                  osc_dn_o,
  input wire logic                  interp_pulse_o,
  input wire logic                  adc_clk_o,
  input wire logic                  store_clk_o,
  input wire logic                  arm_o,
  input wire logic                  done_o,
  // dac load port
  input wire logic [3:0]            dac_sel_o,
  input wire logic [`SAT_DAC_W-1:0] dac_val_o,
  input wire logic                  dac_ld_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // strobes of interest
  sequence s_dac; wr_i && addr_i == `SAT_REG_DAC; endsequence
  sequence s_go; wr_i && addr_i == `SAT_REG_CTRL && wdata_i[`SAT_CTL_START]; endsequence
  // three cycles of completion, so a tick still in flight has landed
  sequence s_held; done_o [*3]; endsequence
  property p_rd_idle; !rd_i |=> rdata_o == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_dac_ld; s_dac |=> dac_ld_o && dac_sel_o == $past(wdata_i[15:12])
    && dac_val_o == $past(wdata_i[11:0]); endproperty
  a_dac_ld: assert property (p_dac_ld) else $error("dac load wrong");
  property p_dac_quiet; !(wr_i && addr_i == `SAT_REG_DAC) |=> !dac_ld_o; endproperty
  a_dac_quiet: assert property (p_dac_quiet) else $error("stray dac load");
  property p_excl; !(arm_o && done_o); endproperty
  a_excl: assert property (p_excl) else $error("armed and done together");
  property p_done_hold; done_o && !(wr_i && addr_i == `SAT_REG_CTRL && wdata_i[0])
    |=> done_o; endproperty
  a_done_hold: assert property (p_done_hold) else $error("done dropped");
  property p_go_clr; s_go ##0 done_o |=> !done_o; endproperty
  a_go_clr: assert property (p_go_clr) else $error("start kept done");
  property p_halt; s_held |-> !adc_clk_o && $stable(store_clk_o); endproperty
  a_halt: assert property (p_halt) else $error("clocks run after done");
  property p_fell; $fell(arm_o) |-> !done_o; endproperty
  a_fell: assert property (p_fell) else $error("done at trigger");
  property p_osc; osc_up_o && osc_dn_o |=> !(osc_up_o && osc_dn_o); endproperty
  a_osc: assert property (p_osc) else $error("phase flags stuck");
  property p_interp; $rose(interp_pulse_o) |-> arm_o || $past(arm_o) || $past(arm_o, 2);
  endproperty
  a_interp: assert property (p_interp) else $error("pulse while unarmed");
  property p_interp_end; interp_pulse_o |-> ##[1:200] !interp_pulse_o; endproperty
  a_interp_end: assert property (p_interp_end) else $error("pulse too long");
endmodule // sat_monitor
bind sat_top sat_monitor u_mon (.sys_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
  .rdata_o, .osc_up_o, .osc_dn_o, .interp_pulse_o, .adc_clk_o, .store_clk_o, .arm_o,
  .done_o, .dac_sel_o, .dac_val_o, .dac_ld_o);
`default_nettype wire

// ===== dv/sat_stretch_model.sv
// interval stretcher stand-in: answers a fixed delay after the pulse.
// assumes the pulse comes from sat_top on the same clock.
`timescale 1ns/1ps
`default_nettype none
module sat_stretch_model #(
  parameter int DLY = 40
) (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  // stretcher handshake
  input  wire logic pulse_i,
  output logic      done_o
);
  logic       prev_r;
  logic [7:0] cnt_r;
  // fixed delay, not width times the factor, so the bench knows the count
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      prev_r <= 1'b0;
      cnt_r  <= 8'h00;
      done_o <= 1'b0;
    end
    else
    begin
      prev_r <= pulse_i;
      if (prev_r && !pulse_i) cnt_r <= 8'(DLY);
      else if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
      done_o <= (cnt_r == 8'h01);
    end
  end
endmodule // sat_stretch_model
`default_nettype wire

// ===== dv/scope_acquisition_timebase_bench.sv
// self-checking bench for sat_top: register port, four trigger sources,
// pre/post sequencing, readout, fine count, cal mux, dac loads.
`include "sat_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module scope_acquisition_timebase_bench;
  localparam int DLY = 40;
  logic        sys_clk_i, rst_i, wr_i, rd_i, osc_i, stretch_done_i;
  logic [3:0]  addr_i, trig_r, dac_sel_o;
  logic [15:0] wdata_i, rdata_o, v;
  logic [7:0]  adc1_i, adc2_i;
  logic [11:0] dac_val_o;
  logic        osc_up_o, osc_dn_o, interp_pulse_o, adc_clk_o, store_clk_o;
  logic        arm_o, done_o, calibration_output_mux_o, dac_ld_o;
  int          n_errors, check_count, ticks, t0, s, j, dv, pre, post;
  integer      seed = 12837;
  logic [3:0]  ra [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hf};
  logic [15:0] rv [6] = '{16'h0000, 16'h0001, `SAT_RST_DIV, `SAT_RST_CNT,
                          `SAT_RST_CNT, 16'h0000};
  sat_top #(.DEPTH(16), .PW(4)) DUT (.sys_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i,
    .rd_i, .rdata_o, .adc1_i, .adc2_i, .cmp1_true_i(trig_r[0]), .cmp2_true_i(trig_r[1]),
    .inter_module_trigger_bus_i(trig_r[2]), .ext_trig_i(trig_r[3]), .osc_i, .osc_up_o,
    .osc_dn_o, .interp_pulse_o, .stretch_done_i, .adc_clk_o, .store_clk_o, .arm_o,
    .done_o, .calibration_output_mux_o, .dac_sel_o, .dac_val_o, .dac_ld_o);
  sat_stretch_model #(.DLY(DLY)) u_str (.sys_clk_i, .rst_i, .pulse_i(interp_pulse_o),
    .done_o(stretch_done_i));
  initial
  begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  // oscillator pin runs free so fast mode always has edges
  always @(posedge sys_clk_i) osc_i <= ~osc_i;
  always @(posedge sys_clk_i) if (adc_clk_o === 1'b1 && !arm_o) ticks <= ticks + 1;
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      n_errors++;
    end
  endtask
  task automatic rchk(input string n, input logic [15:0] lo, hi, g);
    chk(n, 16'h0001, {15'h0000, g >= lo && g <= hi});
  endtask
  task automatic pulse(input int k);
    @(posedge sys_clk_i);
    trig_r[k] <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    trig_r[k] <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
  endtask
  task automatic wait_for(input logic want_done);
    for (int c = 0; c < 5000; c++)
    begin
      @(posedge sys_clk_i);
      #1;
      if ((want_done ? done_o : arm_o) === 1'b1) return;
    end
    $display("mismatch wait expected 1 seen 0");
    n_errors++;
    final_report();
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    {rst_i, wr_i, rd_i, osc_i, addr_i, wdata_i, trig_r} = 28'h8000000;
    {adc1_i, adc2_i, ticks, n_errors, check_count} = '0;
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    // read-only and unmapped writes leave the reset values alone
    wr(`SAT_REG_STAT, 16'hffff);
    wr(4'hf, 16'hffff);
    for (j = 0; j < 6; j++)
    begin
      rd(ra[j], v);
      chk("reset", rv[j], v);
    end
    // one acquisition per source; channel two (s == 1) also runs from the oscillator
    for (s = 0; s < 4; s++)
    begin
      dv = 1 + {$random(seed)} % 3;
      post = 1 + {$random(seed)} % 4;
      pre = 18 + s;
      adc1_i <= 8'($random(seed));
      adc2_i <= 8'($random(seed));
      wr(`SAT_REG_DIV, 16'(dv));
      wr(`SAT_REG_PRE, 16'(pre));
      wr(`SAT_REG_POST, 16'(post));
      t0 = ticks;
      wr(`SAT_REG_CTRL, 16'(s * 2 + (s == 1) * 8 + 1));
      pulse(s);
      chk("early_arm", 0, arm_o);
      chk("early_done", 0, done_o);
      wait_for(1'b0);
      rchk("pre_ticks", 16'(pre - 1), 16'(pre + 2), 16'(ticks - t0));
      pulse((s + 1) % 4);
      chk("other_src", 1, arm_o);
      t0 = ticks;
      pulse(s);
      wait_for(1'b1);
      rchk("post_ticks", 16'(post), 16'(post + 3), 16'(ticks - t0));
      repeat (DLY + 20) @(posedge sys_clk_i);
      rd(`SAT_REG_STAT, v);
      chk("stat", 16'h00f0, {8'h00, v[7:0]});
      rd(`SAT_REG_FINE, v);
      rchk("fine", 16'(DLY), 16'(DLY + 8), v);
      rd(`SAT_REG_WPOS, v);
      rchk("wpos", 16'h0000, 16'h000f, v);
      for (j = 0; j < 16; j++)
      begin
        rd(`SAT_REG_DATA, v);
        chk("data", {adc2_i, adc1_i}, v);
      end
    end
    // self-cal output follows the static level bit
    for (j = 0; j < 2; j++)
    begin
      wr(`SAT_REG_CTRL, 16'(16'h0020 + j * 64));
      repeat (4) @(posedge sys_clk_i);
      chk("cal", 16'(j), calibration_output_mux_o);
    end
    // end channels first, then random ones
    for (j = 0; j < 4; j++)
    begin
      v = {j == 0 ? 4'h0 : j == 1 ? 4'hf : 4'($random(seed)), 12'($random(seed))};
      wr(`SAT_REG_DAC, v);
      #1;
      chk("dac_ld", 1, dac_ld_o);
      chk("dac", v, {dac_sel_o, dac_val_o});
    end
    final_report();
  end
endmodule // scope_acquisition_timebase_bench
`default_nettype wire
